// ---- vqf_pkg.sv ----
/*
  Shared constants for the quad video frame-sync output formatter:
  register map, control field positions, line and field geometry.
  Assumes a single 125 MHz system clock domain.
*/
package vqf_pkg;
  localparam int NUM_CH = 4;
  localparam int CTRL_W = 10;
  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] STAT_ADDR = 8'h04;
  localparam logic [CTRL_W-1:0] CTRL_RST = 10'h000;
  // Control field positions
  localparam int CB_EN     = 0;
  localparam int CB_MEM    = 1;
  localparam int CB_COMPAT = 2;
  localparam int CB_PAL    = 3;
  localparam int CB_STYLE  = 4;
  localparam int CB_CCNT   = 6;
  localparam int CB_W16    = 7;
  localparam int CB_PROC   = 8;
  localparam int CB_CHID   = 9;
  // Status field positions
  localparam int ST_FRESH = 0;
  localparam int ST_NULL  = 4;
  localparam int ST_RD    = 8;
  localparam int ST_WR    = 12;
  localparam int ST_UNSUP = 16;
  localparam logic [1:0] IL_FRAME = 2'b10;
  localparam logic [1:0] IL_PIXEL = 2'b01;
  localparam logic [7:0] TRS_PRE  = 8'hff;
  localparam logic [7:0] TRS_ZERO = 8'h00;
  localparam logic [7:0] BLK_Y    = 8'h10;
  localparam logic [7:0] BLK_C    = 8'h80;
  // Line geometry in 16-bit words, field geometry in lines
  localparam logic [10:0] LEN_525 = 11'd858;
  localparam logic [10:0] HDR_525 = 11'd138;
  localparam logic [10:0] LEN_625 = 11'd864;
  localparam logic [10:0] HDR_625 = 11'd144;
  localparam logic [10:0] TRS_LEN = 11'd4;
  localparam logic [9:0]  VB_525  = 10'd21;
  localparam logic [9:0]  ACT_525 = 10'd240;
  localparam logic [9:0]  VB_625  = 10'd23;
  localparam logic [9:0]  ACT_625 = 10'd288;
  typedef enum logic [1:0] {VQF_BLANK, VQF_ACTIVE, VQF_IDLINE} vqf_line_t;
endpackage : vqf_pkg

// ---- vqf_frame_sync_out.sv ----
/*
  Quad-channel frame synchronizer bank control and BT.656 output
  formatter, with channel-identified and multiplexed output modes.
  Assumes FIFOs and frame memory on ref_clk, and a line clock from
  the clock generator that is sampled here as an asynchronous input.
*/
// The implementer's own choices: the register offsets and the plain strobed port.
// Overview of operation
// - Two frame banks per channel with memory
// - Compatible mode drops or repeats whole frames
// - Non-compatible: one line fewer, repeat, never drop
// - Bypass: shared clock, no frame alignment
// - Source is output or input FIFOs
// - Timing reference FF 00 00 code
// - Blanking levels carry channel index
// - Pixel-interleaved four-channel codes carry index nibble
// - Every line except the ID line has fixed length
// - Outputs share common H, V, F references
// - Decode style, channel count, width
// - Pixel, two channel, 16-bit unsupported
// - Processor mode: four channels, 16-bit port
// - Codes on both luma and chroma lanes in 16-bit mode
// - 524 lines plus identification line
// - Output frame shorter than input frame
// - Null flag when no new frame
// - ID line: EAV, blank, SAV, pairs
// - Pairs = field<<2 | null<<1 | stream0
// - Stream-zero marker only for channel 0
// - 525-line geometry: 21, 240, 858, 138
// - 625-line geometry: 23, 288, 864, 144
`timescale 1ns/1ns
module vqf_frame_sync_out
  import vqf_pkg::*;
(
  input  wire logic                  ref_clk,
  input  wire logic                  sys_rst,
  input  wire logic [7:0]            reg_addr,
  input  wire logic [31:0]           reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [31:0]           reg_rdata,
  input  wire logic                  line_clk,
  input  wire logic [NUM_CH-1:0][15:0] in_fifo_word,
  input  wire logic [NUM_CH-1:0][15:0] out_fifo_word,
  input  wire logic [NUM_CH-1:0]     in_frame_done,
  output logic      [NUM_CH-1:0]     in_fifo_pop,
  output logic      [NUM_CH-1:0]     out_fifo_pop,
  output logic      [NUM_CH-1:0]     wr_bank,
  output logic      [NUM_CH-1:0]     rd_bank,
  output logic      [NUM_CH-1:0]     wr_stall,
  output logic      [7:0]            lane_y,
  output logic      [7:0]            lane_c,
  output logic                       h_ref,
  output logic                       v_ref,
  output logic                       f_ref
);

  function automatic logic [7:0] trs_code(input logic f, input logic v,
                                          input logic h, input logic chtrs,
                                          input logic [1:0] id);
    trs_code = {1'b1, f, v, h, chtrs ? {2'b00, id} : {v ^ h, f ^ h, f ^ v, f ^ v ^ h}};
  endfunction : trs_code

  // Line clock synchronizer; only the agreed level is used
  logic ls1_r, ls2_r, ls3_r, lvl_r, lvl_nxt, tick;
  always_comb begin
    lvl_nxt = (ls2_r == ls3_r) ? ls2_r : lvl_r;
    tick    = (ls2_r == ls3_r) && ls2_r && !lvl_r;
  end
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ls1_r <= 1'b0;
      ls2_r <= 1'b0;
      ls3_r <= 1'b0;
      lvl_r <= 1'b0;
    end else begin
      ls1_r <= line_clk;
      ls2_r <= ls1_r;
      ls3_r <= ls2_r;
      lvl_r <= lvl_nxt;
    end
  end

  // Register file
  logic [CTRL_W-1:0] ctrl_r, ctrl_nxt;
  logic [31:0]       rdata_nxt;
  logic [NUM_CH-1:0] fresh_r, fresh_nxt, null_r, null_nxt;
  logic [NUM_CH-1:0] wr_nxt, rd_nxt, stall_nxt;
  logic en, mem_en, compat, pal, ccnt, w16, proc, chid_en;
  logic [1:0] style;
  logic eff_pix, eff_4, eff_w16, unsup, run, chtrs;
  always_comb begin
    en      = ctrl_r[CB_EN];
    mem_en  = ctrl_r[CB_MEM];
    compat  = ctrl_r[CB_COMPAT];
    pal     = ctrl_r[CB_PAL];
    style   = ctrl_r[CB_STYLE +: 2];
    ccnt    = ctrl_r[CB_CCNT];
    w16     = ctrl_r[CB_W16];
    proc    = ctrl_r[CB_PROC];
    chid_en = ctrl_r[CB_CHID];
    eff_pix = !proc && (style == IL_PIXEL);
    eff_4   = proc || ccnt;
    eff_w16 = proc || w16;
    unsup   = !proc && (style == IL_PIXEL) && !ccnt && w16;
    run     = en && !unsup;
    chtrs   = eff_pix && eff_4;
    ctrl_nxt = ctrl_r;
    if (reg_wr && reg_addr == CTRL_ADDR) begin
      ctrl_nxt = reg_wdata[CTRL_W-1:0];
    end
    rdata_nxt = 32'h0000_0000;
    if (reg_rd) begin
      unique case (reg_addr)
        CTRL_ADDR: rdata_nxt[CTRL_W-1:0] = ctrl_r;
        STAT_ADDR: begin
          rdata_nxt[ST_FRESH +: NUM_CH] = fresh_r;
          rdata_nxt[ST_NULL +: NUM_CH]  = null_r;
          rdata_nxt[ST_RD +: NUM_CH]    = rd_bank;
          rdata_nxt[ST_WR +: NUM_CH]    = wr_bank;
          rdata_nxt[ST_UNSUP]           = unsup;
        end
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
  end
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ctrl_r    <= CTRL_RST;
      reg_rdata <= 32'h0000_0000;
    end else begin
      ctrl_r    <= ctrl_nxt;
      reg_rdata <= rdata_nxt;
    end
  end

  // Timing generator
  logic [10:0] p_r, p_nxt, llen, hdrw, hdr, cur_len, kpos;
  logic [9:0]  line_r, line_nxt, vb, act, fld_lines;
  logic [1:0]  slot_r, slot_nxt, fch_r, fch_nxt, ch, last;
  logic        field_r, field_nxt, fstart;
  logic [2:0]  pairs;
  logic [NUM_CH-1:0] take;
  vqf_line_t   lkind;
  always_comb begin
    llen = pal ? LEN_625 : LEN_525;
    hdrw = pal ? HDR_625 : HDR_525;
    vb   = pal ? VB_625 : VB_525;
    act  = pal ? ACT_625 : ACT_525;
    hdr  = eff_w16 ? hdrw : {hdrw[9:0], 1'b0};
    last = eff_4 ? 2'd3 : 2'd1;
    ch   = eff_pix ? slot_r : fch_r;
    if (line_r < vb) begin
      lkind = VQF_BLANK;
    end else if (line_r < vb + act) begin
      lkind = VQF_ACTIVE;
    end else if (proc && field_r && line_r == vb + act) begin
      lkind = VQF_IDLINE;
    end else begin
      lkind = VQF_BLANK;
    end
    pairs = {field_r, null_r[ch], ch == 2'd0};
    // Fixed lengths; the ID line ends right after its last pair
    if (lkind == VQF_IDLINE) begin
      cur_len = hdr + {5'd0, pairs, 3'b000};
    end else begin
      cur_len = eff_w16 ? llen : {llen[9:0], 1'b0};
    end
    // Trailing lines of field 1: two when compatible or in processor mode, else one
    fld_lines = vb + act + 10'd1
              + {9'd0, field_r && (proc || compat)};
    fstart = tick && run && p_r == 11'd0 && line_r == 10'd0
           && !field_r && slot_r == 2'd0;
    if (!fstart) begin
      take = '0;
    end else if (eff_pix) begin
      take = eff_4 ? 4'hf : 4'h3;
    end else begin
      take = 4'h1 << fch_r;
    end
    p_nxt     = p_r;
    line_nxt  = line_r;
    slot_nxt  = slot_r;
    field_nxt = field_r;
    fch_nxt   = fch_r;
    if (!run) begin
      p_nxt     = 11'd0;
      line_nxt  = 10'd0;
      slot_nxt  = 2'd0;
      field_nxt = 1'b0;
      fch_nxt   = 2'd0;
    end else if (tick) begin
      if (eff_pix && slot_r != last) begin
        slot_nxt = slot_r + 2'd1;
      end else begin
        slot_nxt = 2'd0;
        if (p_r == cur_len - 11'd1) begin
          p_nxt = 11'd0;
          if (line_r == fld_lines - 10'd1) begin
            line_nxt  = 10'd0;
            field_nxt = !field_r;
            // Both fields of a channel stay together, then rotate
            if (field_r) begin
              fch_nxt = (fch_r == last) ? 2'd0 : fch_r + 2'd1;
            end
          end else begin
            line_nxt = line_r + 10'd1;
          end
        end else begin
          p_nxt = p_r + 11'd1;
        end
      end
    end
  end
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      p_r     <= 11'd0;
      line_r  <= 10'd0;
      slot_r  <= 2'd0;
      field_r <= 1'b0;
      fch_r   <= 2'd0;
    end else begin
      p_r     <= p_nxt;
      line_r  <= line_nxt;
      slot_r  <= slot_nxt;
      field_r <= field_nxt;
      fch_r   <= fch_nxt;
    end
  end

  // Output formatter
  logic [7:0]  y_nxt, c_nxt, tb, by, bc;
  logic [15:0] word;
  logic [10:0] q;
  logic        vbit, in_trs, is_eav, pop;
  logic [NUM_CH-1:0] ipop_nxt, opop_nxt;
  logic        h_nxt, v_nxt, f_nxt;
  always_comb begin
    q      = p_r - hdr;
    vbit   = (lkind == VQF_BLANK);
    in_trs = 1'b0;
    is_eav = 1'b1;
    kpos   = p_r;
    if (p_r < TRS_LEN) begin
      in_trs = 1'b1;
    end else if (p_r >= hdr - TRS_LEN && p_r < hdr) begin
      in_trs = 1'b1;
      is_eav = 1'b0;
      kpos   = p_r - (hdr - TRS_LEN);
    end else if (lkind == VQF_IDLINE && p_r >= hdr) begin
      in_trs = 1'b1;
      is_eav = !q[2];
      kpos   = q;
    end
    unique case (kpos[1:0])
      2'd0:    tb = TRS_PRE;
      2'd3:    tb = trs_code(field_r, vbit, is_eav, chtrs, ch);
      default: tb = TRS_ZERO;
    endcase
    by   = BLK_Y | (chid_en ? {6'd0, ch} : 8'h00);
    bc   = BLK_C | (chid_en ? {6'd0, ch} : 8'h00);
    word = mem_en ? out_fifo_word[ch] : in_fifo_word[ch];
    pop  = 1'b0;
    if (in_trs) begin
      y_nxt = tb;
      c_nxt = eff_w16 ? tb : 8'h00;
    end else if (p_r < hdr || lkind != VQF_ACTIVE) begin
      y_nxt = (eff_w16 || p_r[0]) ? by : bc;
      c_nxt = eff_w16 ? bc : 8'h00;
    end else begin
      pop   = eff_w16 || p_r[0];
      y_nxt = (eff_w16 || p_r[0]) ? word[15:8] : word[7:0];
      c_nxt = eff_w16 ? word[7:0] : 8'h00;
    end
    h_nxt = p_r < hdr;
    v_nxt = lkind != VQF_ACTIVE && lkind != VQF_IDLINE;
    f_nxt = field_r;
    ipop_nxt = '0;
    opop_nxt = '0;
    if (tick && run && pop) begin
      ipop_nxt[ch] = !mem_en;
      opop_nxt[ch] = mem_en;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (sys_rst || !run) begin
      lane_y       <= 8'h00;
      lane_c       <= 8'h00;
      h_ref        <= 1'b0;
      v_ref        <= 1'b0;
      f_ref        <= 1'b0;
      in_fifo_pop  <= '0;
      out_fifo_pop <= '0;
    end else begin
      if (tick) begin
        lane_y <= y_nxt;
        lane_c <= c_nxt;
        h_ref  <= h_nxt;
        v_ref  <= v_nxt;
        f_ref  <= f_nxt;
      end
      in_fifo_pop  <= ipop_nxt;
      out_fifo_pop <= opop_nxt;
    end
  end

  // Double-buffer control; writer owns wr_bank, reader owns rd_bank
  always_comb begin
    fresh_nxt = fresh_r;
    null_nxt  = null_r;
    wr_nxt    = wr_bank;
    rd_nxt    = rd_bank;
    for (int c = 0; c < NUM_CH; c++) begin
      if (take[c]) begin
        null_nxt[c] = !(fresh_r[c] || in_frame_done[c]);
      end
      // A frame finishing at the take is consumed, not lost
      if (take[c] && (fresh_r[c] || in_frame_done[c])) begin
        rd_nxt[c]    = wr_bank[c];
        wr_nxt[c]    = ~wr_bank[c];
        fresh_nxt[c] = 1'b0;
      end else if (in_frame_done[c]) begin
        // Compatible mode overwrites the waiting frame: a drop
        fresh_nxt[c] = 1'b1;
      end
    end
    // Non-compatible mode holds the writer instead of dropping
    stall_nxt = mem_en && !compat ? fresh_nxt : '0;
  end
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      fresh_r  <= '0;
      null_r   <= '0;
      wr_bank  <= '0;
      rd_bank  <= '1;
      wr_stall <= '0;
    end else begin
      fresh_r  <= fresh_nxt;
      null_r   <= null_nxt;
      wr_bank  <= wr_nxt;
      rd_bank  <= rd_nxt;
      wr_stall <= stall_nxt;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  chk_trs_preamble: assert property (
    tick && run && p_r == 11'd0 |=> lane_y == 8'hff)
    else $error("EAV preamble byte wrong");
  chk_trs_active_code: assert property (
    tick && run && !chtrs && p_r == 11'd3 && lkind == VQF_ACTIVE && field_r
    |=> lane_y == 8'hda)
    else $error("Active even-field EAV code wrong");
  chk_blank_chan_id: assert property (
    tick && run && chid_en && eff_w16 && p_r == 11'd4
    |=> lane_y == (8'h10 | {6'd0, $past(ch)}) && lane_c == (8'h80 | {6'd0, $past(ch)}))
    else $error("Blanking level lacks channel index");
  chk_chan_trs_nibble: assert property (
    tick && run && chtrs && p_r == 11'd3 |=> lane_y[3:0] == {2'b00, $past(slot_r)})
    else $error("Channel code nibble wrong");
  chk_unsup_idle: assert property (
    unsup |=> lane_y == 8'h00 && in_fifo_pop == '0 && out_fifo_pop == '0)
    else $error("Unsupported mode produced output");
  chk_both_lanes: assert property (
    tick && run && proc && p_r == 11'd0 |=> lane_c == 8'hff && lane_y == 8'hff)
    else $error("Timing code missing on chroma lane");
  chk_pop_source: assert property (
    tick && run && lkind == VQF_ACTIVE && eff_w16 && p_r == hdr
    |=> (mem_en ? out_fifo_pop != '0 : in_fifo_pop != '0)
        && (in_fifo_pop & out_fifo_pop) == '0)
    else $error("Pixel popped from wrong FIFO");
  chk_id_line_end: assert property (
    tick && run && lkind == VQF_IDLINE && p_r == hdr + {5'd0, pairs, 3'b000} - 11'd1
    |=> p_r == 11'd0 && line_r == $past(line_r) + 10'd1)
    else $error("ID line did not end after last pair");
  chk_frame_repeat: assert property (
    take[0] && !fresh_r[0] && !in_frame_done[0]
    |=> rd_bank[0] == $past(rd_bank[0]) && null_r[0])
    else $error("Missing frame not repeated");
  chk_noncompat_hold: assert property (
    mem_en && !compat && in_frame_done[1] && !take[1] |=> wr_stall[1] && fresh_r[1])
    else $error("Writer not held in non-compatible mode");

endmodule : vqf_frame_sync_out

// ---- vqf_video_sink.sv ----
/*
  Far-side receiver model: makes the free-running line clock and
  captures the luma and chroma lanes once per line-clock slot.
  Assumes the formatter updates its lanes within half a slot of a tick.
*/
`timescale 1ns/1ns
module vqf_video_sink (
  output logic             line_clk,
  input  wire logic        arm,
  input  wire logic [7:0]  lane_y,
  input  wire logic [7:0]  lane_c
);
  logic [7:0] cap_y [$];
  logic [7:0] cap_c [$];

  // Phase offset keeps the link clock edges off the system clock edges
  initial begin
    line_clk = 1'b0;
    #3;
    forever #40 line_clk = ~line_clk;
  end

  // Sample just before the next tick, where the previous slot is settled
  always @(posedge line_clk) begin
    if (arm) begin
      cap_y.push_back(lane_y);
      cap_c.push_back(lane_c);
    end else begin
      cap_y.delete();
      cap_c.delete();
    end
  end
endmodule : vqf_video_sink

// ---- vqf_frame_sync_out_tb.sv ----
/*
  Self-checking bench for the frame-sync output formatter: register
  access, bank swap, processor-mode line timing, pixel-interleaved codes,
  two-channel frame interleave with 625-line geometry.
  Assumes the receiver model supplies the line clock.
*/
`timescale 1ns/1ns
module vqf_frame_sync_out_tb
  import vqf_pkg::*;
;
  logic                      ref_clk;
  logic                      sys_rst;
  logic [7:0]                reg_addr;
  logic [31:0]               reg_wdata;
  logic                      reg_wr;
  logic                      reg_rd;
  logic [31:0]               reg_rdata;
  logic                      line_clk;
  logic [NUM_CH-1:0][15:0]   in_w;
  logic [NUM_CH-1:0][15:0]   out_w;
  logic [NUM_CH-1:0]         in_frame_done;
  logic [NUM_CH-1:0]         wr_stall;
  logic [NUM_CH-1:0]         in_pop;
  logic [NUM_CH-1:0]         out_pop;
  logic [NUM_CH-1:0]         pop_seen;
  logic                      h_ref;
  logic                      v_ref;
  logic                      f_ref;
  logic [7:0]                lane_y;
  logic [7:0]                lane_c;
  logic                      arm;
  logic [31:0]               v;
  int                        failures;
  int                        n_checks;
  int                        b;

  vqf_frame_sync_out vqf_frame_sync_out_i (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .line_clk(line_clk), .in_fifo_word(in_w),
    .out_fifo_word(out_w), .in_frame_done(in_frame_done), .in_fifo_pop(in_pop),
    .out_fifo_pop(out_pop), .wr_bank(), .rd_bank(), .wr_stall(wr_stall),
    .lane_y(lane_y), .lane_c(lane_c), .h_ref(h_ref), .v_ref(v_ref), .f_ref(f_ref)
  );
  vqf_video_sink vqf_video_sink_i (
    .line_clk(line_clk), .arm(arm), .lane_y(lane_y), .lane_c(lane_c)
  );

  initial ref_clk = 1'b0;
  always #4 ref_clk = ~ref_clk;

  // FIFO contents are random; data words may mimic sync bytes only by chance
  always @(posedge ref_clk) begin
    in_w  <= {$urandom, $urandom};
    out_w <= {$urandom, $urandom};
  end

  // The runs reach blank lines only, so any pop is a fault
  always @(posedge ref_clk) begin
    if (sys_rst) pop_seen <= '0;
    else pop_seen <= pop_seen | in_pop | out_pop;
  end

  function automatic logic [7:0] code_of(input logic f, input logic vb, input logic h);
    code_of = {1'b1, f, vb, h, vb ^ h, f ^ h, f ^ vb, f ^ vb ^ h};
  endfunction : code_of

  function automatic int find_ff();
    find_ff = -1;
    foreach (vqf_video_sink_i.cap_y[k]) begin
      if (find_ff < 0 && vqf_video_sink_i.cap_y[k] === TRS_PRE) find_ff = k;
    end
  endfunction : find_ff

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    @(negedge ref_clk);
    d = reg_rdata;
  endtask : rd

  // Checks a four-word timing reference on one lane of the capture
  task automatic chk_trs(input string nm, input int i, input logic [7:0] code, input bit y);
    for (int k = 0; k < 4; k++) begin
      chk(nm, (k == 0) ? TRS_PRE : (k == 3) ? code : TRS_ZERO,
          y ? vqf_video_sink_i.cap_y[i+k] : vqf_video_sink_i.cap_c[i+k]);
    end
  endtask : chk_trs

  task automatic finish_test();
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : finish_test

  initial begin
    repeat (40000) @(posedge ref_clk);
    failures++;
    finish_test();
  end

  initial begin
    sys_rst = 1'b1; reg_addr = 8'h00; reg_wdata = 32'h0; reg_wr = 1'b0; reg_rd = 1'b0;
    in_w = '0; out_w = '0; in_frame_done = '0; arm = 1'b0;
    failures = 0; n_checks = 0;
    void'($urandom(35));
    repeat (20) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rd(STAT_ADDR, v); chk("status_reset", 32'h0000_0f00, v);
    rd(CTRL_ADDR, v); chk("ctrl_reset", {22'h0, CTRL_RST}, v);
    wr(8'h08, 32'hffff_ffff);
    rd(8'h08, v); chk("unmapped", 32'h0, v);
    // Frame done while stopped: non-compatible memory mode stalls the writer
    wr(CTRL_ADDR, 32'h1 << CB_MEM);
    @(posedge ref_clk) in_frame_done <= 4'h3;
    @(posedge ref_clk) in_frame_done <= 4'h0;
    repeat (2) @(posedge ref_clk);
    chk("wr_stall01", 32'h3, {30'h0, wr_stall[1:0]});
    rd(STAT_ADDR, v); chk("fresh0", 32'h1, v & 32'h1);
    b = (1 << CB_EN) | (1 << CB_MEM) | (1 << CB_PROC) | (1 << CB_CHID);
    wr(CTRL_ADDR, b);
    rd(CTRL_ADDR, v); chk("ctrl_rb", b, v);
    arm <= 1'b1;
    repeat (9200) @(posedge ref_clk);
    rd(STAT_ADDR, v); chk("bank_swap", 32'h0000_1000, v & 32'h0001_1111);
    chk("hvf_blank", 32'h6, {29'h0, h_ref, v_ref, f_ref});
    b = find_ff();
    chk_trs("eav_y", b, code_of(0, 1, 1), 1);
    chk_trs("eav_c", b, code_of(0, 1, 1), 0);
    chk_trs("sav_y", b + HDR_525 - 4, code_of(0, 1, 0), 1);
    chk_trs("sav_c", b + HDR_525 - 4, code_of(0, 1, 0), 0);
    chk_trs("eav2_y", b + LEN_525, code_of(0, 1, 1), 1);
    // Pixel interleave, four channels, 8-bit, channel-coded blanking
    wr(CTRL_ADDR, 32'h0);
    arm <= 1'b0;
    repeat (30) @(posedge ref_clk);
    arm <= 1'b1;
    wr(CTRL_ADDR, (1 << CB_EN) | (IL_PIXEL << CB_STYLE) | (1 << CB_CCNT) | (1 << CB_CHID));
    repeat (500) @(posedge ref_clk);
    b = find_ff();
    for (int s = 0; s < 4; s++) begin
      chk("pix_pre", TRS_PRE, vqf_video_sink_i.cap_y[b+s]);
      chk("pix_code", {code_of(0, 1, 1) & 8'hf0} | s, vqf_video_sink_i.cap_y[b+12+s]);
    end
    chk("blank_c1", BLK_C + 8'h01, vqf_video_sink_i.cap_y[b+17]);
    chk("blank_y1", BLK_Y + 8'h01, vqf_video_sink_i.cap_y[b+21]);
    // Frame interleave, two channels, 16-bit, 625-line geometry, compatible
    wr(CTRL_ADDR, 32'h0);
    arm <= 1'b0;
    repeat (30) @(posedge ref_clk);
    arm <= 1'b1;
    wr(CTRL_ADDR, (1 << CB_EN) | (1 << CB_COMPAT) | (1 << CB_PAL)
                  | (IL_FRAME << CB_STYLE) | (1 << CB_W16));
    repeat (9000) @(posedge ref_clk);
    b = find_ff();
    chk_trs("pal_eav_y", b, code_of(0, 1, 1), 1);
    chk_trs("pal_sav_y", b + HDR_625 - 4, code_of(0, 1, 0), 1);
    chk_trs("pal_sav_c", b + HDR_625 - 4, code_of(0, 1, 0), 0);
    chk_trs("pal_eav2_y", b + LEN_625, code_of(0, 1, 1), 1);
    // Unsupported combination stays idle and is flagged
    wr(CTRL_ADDR, 32'h0);
    wr(CTRL_ADDR, (1 << CB_EN) | (IL_PIXEL << CB_STYLE) | (1 << CB_W16));
    rd(STAT_ADDR, v); chk("unsup", 32'h1, (v >> ST_UNSUP) & 32'h1);
    repeat (200) @(posedge ref_clk);
    chk("unsup_idle", 32'h0, {24'h0, lane_y});
    chk("blank_pops", 32'h0, {28'h0, pop_seen});
    finish_test();
  end
endmodule : vqf_frame_sync_out_tb
